// ===== isv_pkg.sv
// package of constants for the interrupt source and vectoring block
package isv_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_SYSCTL   = 8'h00;
  localparam logic [7:0] OFF_PRIO_1   = 8'h04;
  localparam logic [7:0] OFF_PRIO_2   = 8'h08;
  localparam logic [7:0] OFF_FLAGS    = 8'h0C;
  localparam logic [7:0] OFF_ENABLE   = 8'h10;
  localparam logic [7:0] OFF_SENSE    = 8'h14;
  localparam logic [7:0] OFF_STATUS   = 8'h18;
  localparam logic [7:0] OFF_HANDLED  = 8'h1C;
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int          NMI_EDGE_BIT = 2;
  localparam int          N_LINES      = 5;
  localparam int          N_INT        = 21;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [7:0]  LINE_MASK    = 8'h1F;
  // vector numbers
  localparam logic [5:0]  VEC_NMI      = 6'h07;
  localparam logic [5:0]  VEC_LINE0    = 6'h0C;
  localparam logic [5:0]  VEC_WDT      = 6'h14;
  localparam logic [5:0]  VEC_TMR0     = 6'h18;
  localparam logic [5:0]  VEC_SER      = 6'h34;
  localparam logic [5:0]  VEC_CONV     = 6'h3C;
  localparam logic [5:0]  VEC_NONE     = 6'h00;
  localparam int          VEC_COUNT    = 64;
  // the vector entry address is vector shifted left by this many bits
  localparam int          VEC_SHIFT    = 2;
  localparam logic [31:0] SLVERR_NONE  = 32'h0000_0000;
endpackage

// ===== isv_req_if.sv
// interface carrying the request vector from sources to the priority resolver
interface isv_req_if;
  logic [63:0] pend;
  logic [63:0] high;
  logic        nmi;
  logic [5:0]  vec;
  logic        valid;
  logic        level;
  modport src (output pend, output high, output nmi, input vec, input valid, input level);
  modport res (input pend, input high, input nmi, output vec, output valid, output level);
endinterface

// ===== isv_resolve.sv
// priority resolver: picks the winning vector among pending sources
module isv_resolve (
  isv_req_if.res r
);
  // ----------------------------------------------------------------
  // search from the largest vector down so the smallest wins
  // ----------------------------------------------------------------
  always_comb begin
    r.vec   = isv_pkg::VEC_NONE;
    r.valid = 1'b0;
    r.level = 1'b0;
    for (int i = isv_pkg::VEC_COUNT - 1; i >= 0; i--) begin
      if (r.pend[i] && !r.high[i] && !r.level) begin
        r.vec   = 6'(i);
        r.valid = 1'b1;
      end
    end
    for (int i = isv_pkg::VEC_COUNT - 1; i >= 0; i--) begin
      if (r.pend[i] && r.high[i]) begin
        r.vec   = 6'(i);
        r.valid = 1'b1;
        r.level = 1'b1;
      end
    end
    if (r.nmi) begin
      r.vec   = isv_pkg::VEC_NMI;
      r.valid = 1'b1;
      r.level = 1'b1;
    end
  end
endmodule

// ===== isv_top.sv
// interrupt source detection, status flags and vector selection
// What this block does
// - six external sources; nmi and lines 0-2 raise a standby wake output
// - nmi outranks everything and ignores all masking
// - system control bit picks rising or falling nmi edge
// - nmi uses vector 7, entry at 0x001C
// - each line requests on low level or falling edge
// - sense bit 0 is level (reset), 1 is falling edge
// - per line enable; lines 2 and 3 share one priority bit
// - line flags show pending state and software clears them
// - flag set/clear by level, edge, write-0-after-read-1, or handling
// - lines 0-4 use vectors 12-16, entries from 0x0030
// - line inputs sensed regardless of pin direction
// - 21 internal requests, module-gated, priorities from two registers
// - equal level: smaller vector number wins
// - priority bits change order; reset gives default order
// - entry address is vector number times four
// - timer channels on 24+4n, three vectors, own priority bit
// - serial requests on vectors 52-55 sharing one bit
// - watchdog vector 20, converter vector 60, own bits
// - priority bit 0 is low level (reset), 1 is high
//
// The address map and register access over APB were decided locally.
module isv_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        nmi_pin,
  input  wire logic [4:0]  line_pin_n,
  input  wire logic [4:0]  compare_a_request,
  input  wire logic [4:0]  compare_b_request,
  input  wire logic [4:0]  counter_overflow_request,
  input  wire logic        watchdog_interval_request,
  input  wire logic        receive_error_request,
  input  wire logic        receive_full_request,
  input  wire logic        transmit_empty_request,
  input  wire logic        transmit_end_request,
  input  wire logic        conversion_end_request,
  input  wire logic        handling_done,
  input  wire logic [5:0]  handling_vec,
  output logic             irq_valid,
  output logic [5:0]       irq_vector,
  output logic [15:0]      irq_entry_addr,
  output logic             irq_level,
  output logic             irq_nmi,
  output logic             standby_wake
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // 8-bit registers, each in the low byte of its word
  logic [7:0] system_control_reg;
  logic [7:0] priority_level_first;
  logic [7:0] priority_level_second;
  logic [7:0] line_enable_reg;
  logic [7:0] sense_select_reg;
  logic [4:0] line_pending_flag;
  logic [4:0] flag_seen_one;
  // edge history for the nmi and line pins
  logic [4:0] line_prev;
  logic       nmi_prev;
  logic       nmi_pend;
  logic [5:0] last_handled;

  logic       wr_en;
  logic       rd_en;
  logic       nmi_edge;
  logic [4:0] line_low;
  logic [4:0] line_fall;
  logic [4:0] line_set;
  logic [4:0] line_clr;
  logic [4:0] sw_clr;
  logic [4:0] hs_clr;
  logic [4:0] line_prio;
  logic [4:0] timer_prio;
  logic       nmi_rise;
  logic       nmi_fall;

  // ----------------------------------------------------------------
  // priority resolver
  // ----------------------------------------------------------------
  // pending and level words are indexed by vector number, so the
  // resolver needs no table of its own
  isv_req_if req ();

  isv_resolve u_resolve (
    .r (req.res)
  );

  // read data and the read-seen mark are both taken at the setup edge, so a
  // later write of 0 clears only flags that software saw as 1
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // ----------------------------------------------------------------
  // input edge detection
  // ----------------------------------------------------------------
  // pins are taken as synchronous; one stage of history per pin
  // line history resets high, the idle level, so release brings no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_prev  <= 1'b0;
      line_prev <= 5'h1F;
    end else begin
      nmi_prev  <= nmi_pin;
      line_prev <= line_pin_n;
    end
  end

  // rising edge when the select bit is 1, else falling edge
  assign nmi_rise  = nmi_pin && !nmi_prev;
  assign nmi_fall  = !nmi_pin && nmi_prev;
  assign nmi_edge  = system_control_reg[isv_pkg::NMI_EDGE_BIT] ? nmi_rise : nmi_fall;
  // pins are active low: a low level or a high-to-low step requests
  assign line_low  = ~line_pin_n;
  assign line_fall = line_prev & ~line_pin_n;

  // ----------------------------------------------------------------
  // line flag set and clear terms
  // ----------------------------------------------------------------
  // level mode re-sets the flag each cycle the pin is low, so a clear sticks only once it is high
  always_comb begin
    for (int n = 0; n < isv_pkg::N_LINES; n++) begin
      line_set[n] = sense_select_reg[n] ? line_fall[n] : line_low[n];
      hs_clr[n]   = handling_done && (handling_vec == 6'(isv_pkg::VEC_LINE0 + 6'(n)))
                    && (sense_select_reg[n] || line_pin_n[n]);
      sw_clr[n]   = wr_en && (paddr == isv_pkg::OFF_FLAGS) && !pwdata[n] && flag_seen_one[n];
      line_clr[n] = hs_clr[n] || sw_clr[n];
    end
  end

  // set wins over a clear landing in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_pending_flag <= 5'h00;
    end else begin
      line_pending_flag <= line_set | (line_pending_flag & ~line_clr);
    end
  end

  // remembers that software read a flag as 1, arming the write-0 clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_seen_one <= 5'h00;
    end else if (rd_en && paddr == isv_pkg::OFF_FLAGS) begin
      flag_seen_one <= line_pending_flag;
    end else begin
      flag_seen_one <= flag_seen_one & ~line_clr;
    end
  end

  // nmi latched until its handling, ignores every enable
  // an edge in the cycle of its handling wins and keeps it pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_pend <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend <= 1'b1;
    end else if (handling_done && handling_vec == isv_pkg::VEC_NMI) begin
      nmi_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control register writes
  // ----------------------------------------------------------------
  // reserved bits are kept and read back but steer nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_control_reg    <= isv_pkg::REG_RESET;
      priority_level_first  <= isv_pkg::REG_RESET;
      priority_level_second <= isv_pkg::REG_RESET;
      line_enable_reg       <= isv_pkg::REG_RESET;
      sense_select_reg      <= isv_pkg::REG_RESET;
    end else if (wr_en) begin
      case (paddr)
        isv_pkg::OFF_SYSCTL: system_control_reg    <= pwdata[7:0];
        isv_pkg::OFF_PRIO_1: priority_level_first  <= pwdata[7:0];
        isv_pkg::OFF_PRIO_2: priority_level_second <= pwdata[7:0];
        isv_pkg::OFF_ENABLE: line_enable_reg       <= pwdata[7:0];
        isv_pkg::OFF_SENSE:  sense_select_reg      <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // records the last vector taken by the core, for software
  // a diagnostic only; nothing in this block acts on it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_handled <= isv_pkg::VEC_NONE;
    end else if (handling_done) begin
      last_handled <= handling_vec;
    end
  end

  // ----------------------------------------------------------------
  // build pending and priority vectors
  // ----------------------------------------------------------------
  // lines 2 and 3 share bit 5; lines 0,1,4 use bits 7,6,4
  assign line_prio = {priority_level_first[4], priority_level_first[5], priority_level_first[5],
                      priority_level_first[6], priority_level_first[7]};
  // timer channels 0..2 use bits 2..0 of the first word, 3 and 4 use bits 7 and 6 of the second
  assign timer_prio = {priority_level_second[6], priority_level_second[7], priority_level_first[0],
                       priority_level_first[1], priority_level_first[2]};

  // masking by the core's global and user mask bits happens in the core, not here
  always_comb begin
    req.pend = 64'h0;
    req.high = 64'h0;
    req.nmi  = nmi_pend;
    for (int n = 0; n < isv_pkg::N_LINES; n++) begin
      req.pend[isv_pkg::VEC_LINE0 + 6'(n)] = line_pending_flag[n] && line_enable_reg[n];
      req.high[isv_pkg::VEC_LINE0 + 6'(n)] = line_prio[n];
    end
    // source modules gate their own requests; only the level comes from here
    for (int c = 0; c < 5; c++) begin
      req.pend[isv_pkg::VEC_TMR0 + 6'(4 * c)]     = compare_a_request[c];
      req.pend[isv_pkg::VEC_TMR0 + 6'(4 * c + 1)] = compare_b_request[c];
      req.pend[isv_pkg::VEC_TMR0 + 6'(4 * c + 2)] = counter_overflow_request[c];
      for (int k = 0; k < 3; k++) begin
        req.high[isv_pkg::VEC_TMR0 + 6'(4 * c + k)] = timer_prio[c];
      end
    end
    req.pend[isv_pkg::VEC_WDT] = watchdog_interval_request;
    req.high[isv_pkg::VEC_WDT] = priority_level_first[3];
    req.pend[isv_pkg::VEC_SER]              = receive_error_request;
    req.pend[isv_pkg::VEC_SER + 6'h01]      = receive_full_request;
    req.pend[isv_pkg::VEC_SER + 6'h02]      = transmit_empty_request;
    req.pend[isv_pkg::VEC_SER + 6'h03]      = transmit_end_request;
    for (int k = 0; k < 4; k++) begin
      req.high[isv_pkg::VEC_SER + 6'(k)] = priority_level_second[3];
    end
    req.pend[isv_pkg::VEC_CONV] = conversion_end_request;
    req.high[isv_pkg::VEC_CONV] = priority_level_second[1];
    // unlisted vector slots stay zero, so reserved vectors never win
  end

  // ----------------------------------------------------------------
  // registered outputs toward the core
  // ----------------------------------------------------------------
  // one cycle of latency buys a glitch-free view for the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_valid      <= 1'b0;
      irq_vector     <= isv_pkg::VEC_NONE;
      irq_entry_addr <= 16'h0000;
      irq_level      <= 1'b0;
      irq_nmi        <= 1'b0;
    end else begin
      irq_valid      <= req.valid;
      irq_vector     <= req.vec;
      irq_entry_addr <= {8'h00, req.vec, 2'b00};
      irq_level      <= req.level;
      irq_nmi        <= req.nmi;
    end
  end

  // wake from standby only from nmi or lines 0..2
  // lines 3 and 4 still request, they just cannot end standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_wake <= 1'b0;
    end else begin
      standby_wake <= nmi_pend || |(line_pending_flag[2:0] & line_enable_reg[2:0]);
    end
  end

  // ----------------------------------------------------------------
  // apb slave: zero wait, reads registered at the setup edge
  // ----------------------------------------------------------------
  // pslverr stays low: unmapped offsets read zero and ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= isv_pkg::SLVERR_NONE;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (rd_en) begin
        case (paddr)
          isv_pkg::OFF_SYSCTL:  prdata <= {24'h0, system_control_reg};
          isv_pkg::OFF_PRIO_1:  prdata <= {24'h0, priority_level_first};
          isv_pkg::OFF_PRIO_2:  prdata <= {24'h0, priority_level_second};
          isv_pkg::OFF_FLAGS:   prdata <= {27'h0, line_pending_flag};
          isv_pkg::OFF_ENABLE:  prdata <= {24'h0, line_enable_reg};
          isv_pkg::OFF_SENSE:   prdata <= {24'h0, sense_select_reg};
          isv_pkg::OFF_STATUS:  prdata <= {17'h0, req.nmi, req.level, req.valid, 6'h0, req.vec};
          isv_pkg::OFF_HANDLED: prdata <= {26'h0, last_handled};
          default:              prdata <= isv_pkg::SLVERR_NONE;
        endcase
      end
    end
  end
endmodule

// ===== isv_checker.sv
// assertion checker for the interrupt source and vectoring block
module isv_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [4:0]  compare_a_request,
  input wire logic        watchdog_interval_request,
  input wire logic        conversion_end_request,
  input wire logic        handling_done,
  input wire logic [5:0]  handling_vec,
  input wire logic        irq_valid,
  input wire logic [5:0]  irq_vector,
  input wire logic [15:0] irq_entry_addr,
  input wire logic        irq_level,
  input wire logic        irq_nmi
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // vector outputs
  // ----------------------------------------
  entry_addr_a: assert property (irq_valid |-> irq_entry_addr == {8'h00, irq_vector, 2'b00})
    else $error("entry address is not vector times four");
  nmi_vector_a: assert property (irq_nmi |-> irq_valid && irq_vector == 6'h07)
    else $error("pending nmi not presented on vector 7");
  nmi_only_a: assert property (irq_valid && !irq_nmi |-> irq_vector != 6'h07)
    else $error("vector 7 shown without nmi");
  nmi_level_a: assert property (irq_nmi |-> irq_level)
    else $error("nmi not shown at the top level");
  logic nmi_taken_q;
  // a take of vector 7 clears the pending bit one edge later and the output one more
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_taken_q <= 1'b0;
    end else begin
      nmi_taken_q <= handling_done && handling_vec == 6'h07;
    end
  end
  // nmi stays pending until the core takes vector 7; masking never drops it
  nmi_hold_a: assert property (irq_nmi && !(handling_done && handling_vec == 6'h07) && !nmi_taken_q |=> irq_nmi)
    else $error("nmi dropped without handling");
  legal_vec_a: assert property (irq_valid |-> irq_vector inside {7, [12:16], 20, [24:26], [28:30], [32:34],
    [36:38], [40:42], [52:55], 60})
    else $error("request on a reserved vector");
  // ----------------------------------------
  // internal sources reach the output
  // ----------------------------------------
  wdt_req_a: assert property (watchdog_interval_request |-> ##[1:3] irq_valid)
    else $error("watchdog request not presented");
  conv_req_a: assert property (conversion_end_request |-> ##[1:3] irq_valid)
    else $error("conversion end request not presented");
  timer_req_a: assert property (|compare_a_request |-> ##[1:3] irq_valid)
    else $error("timer request not presented");
endmodule
bind isv_top isv_checker isv_checker_i (.pclk, .presetn, .compare_a_request, .watchdog_interval_request,
  .conversion_end_request, .handling_done, .handling_vec, .irq_valid, .irq_vector, .irq_entry_addr,
  .irq_level, .irq_nmi);

// ===== isv_core_model.sv
// model of the core's exception entry, taking the presented winner
module isv_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       accept,
  input  wire logic [3:0] delay,
  input  wire logic       irq_valid,
  input  wire logic [5:0] irq_vector,
  output logic            handling_done,
  output logic [5:0]      handling_vec
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_cnt;
  // accepts any winner, nmi included, after a wait; delay of 3 or more
  // keeps it from taking a request twice before the flag clear shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      handling_done <= 1'b0;
      handling_vec  <= 6'h00;
      wait_cnt      <= 4'h0;
    end else if (accept && irq_valid && wait_cnt >= delay) begin
      handling_done <= 1'b1;
      handling_vec  <= irq_vector;
      wait_cnt      <= 4'h0;
    end else begin
      handling_done <= 1'b0;
      handling_vec  <= ~handling_vec; // released vector is not held
      wait_cnt      <= (accept && irq_valid) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// ===== tb_top.sv
// self-checking bench for the interrupt source and vectoring block
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, nmi_pin = 0, accept = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, r, seed = 32'h6D51;
  logic [4:0]  line_pin_n = 5'h1F, cha = 0, chb = 0, ovf = 0;
  logic [3:0]  ser = 0, delay = 4'h3;
  logic        wdt = 0, cnv = 0, pready, pslverr, hdone, irq_valid, irq_level, irq_nmi, standby_wake;
  logic [5:0]  hvec, irq_vector;
  logic [15:0] irq_entry_addr;
  int          bad_count = 0, samples_checked = 0, en_m = 0, p1_m = 0, p2_m = 0, flg_m = 0, nmi_m = 0;
  isv_top isv_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .nmi_pin, .line_pin_n, .compare_a_request(cha), .compare_b_request(chb), .counter_overflow_request(ovf),
    .watchdog_interval_request(wdt), .receive_error_request(ser[0]), .receive_full_request(ser[1]),
    .transmit_empty_request(ser[2]), .transmit_end_request(ser[3]), .conversion_end_request(cnv),
    .handling_done(hdone), .handling_vec(hvec), .irq_valid, .irq_vector, .irq_entry_addr, .irq_level,
    .irq_nmi, .standby_wake);
  isv_core_model isv_core_model_i (.pclk, .presetn, .accept, .delay, .irq_valid, .irq_vector,
    .handling_done(hdone), .handling_vec(hvec));
  always #50 pclk = ~pclk;
  // ----------------------------------------
  // bus, random source and reference model
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // one transfer; pready and prdata are read before that edge's updates land
  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  function automatic bit hi(int v);
    if (v >= 12 && v <= 16) return p1_m[(v == 12) ? 7 : (v == 13) ? 6 : (v <= 15) ? 5 : 4];
    if (v == 20) return p1_m[3];
    if (v >= 24 && v <= 34) return p1_m[2 - (v - 24) / 4];
    if (v >= 36 && v <= 42) return p2_m[7 - (v - 36) / 4];
    if (v >= 52 && v <= 55) return p2_m[3];
    return (v == 60) && p2_m[1];
  endfunction
  // level 1 before level 0, smaller vector first within a level
  task automatic check_irq();
    bit [63:0] pend;
    int w;
    pend = 0;
    w = 0;
    for (int i = 0; i < 5; i++) begin
      pend[12 + i] = flg_m[i] & en_m[i];
      pend[24 + 4 * i +: 3] = {ovf[i], chb[i], cha[i]};
    end
    {pend[60], pend[55:52], pend[20]} = {cnv, ser, wdt};
    for (int v = 63; v > 0; v--) if (pend[v] && (w == 0 || hi(v) >= hi(w))) w = v;
    if (nmi_m != 0) w = 7;
    `CHK(irq_valid, 1'(w != 0))
    `CHK(irq_vector, 6'(w))
    `CHK(irq_entry_addr, 16'(w * 4))
    `CHK(irq_level, 1'(w == 7 || (w != 0 && hi(w))))
    `CHK(irq_nmi, 1'(nmi_m != 0))
    @(posedge pclk); // hand back on an edge so the next drive lands on it
  endtask
  task automatic settle();
    repeat (4) @(posedge pclk);
    #1;
  endtask
  task automatic final_report();
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    final_report();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 36; a += 4) rdc(8'(a), 32'h0);
    apb(1'b1, 8'h20, 32'hFF);
    rdc(8'h20, 32'h0);
    // level lines one at a time, core answering fast and slow
    apb(1'b1, isv_pkg::OFF_ENABLE, 32'h1F);
    en_m = 31;
    for (int i = 0; i < 5; i++) begin
      {accept, delay} <= {1'b1, 4'(3 + 6 * (i % 2))};
      line_pin_n[i] <= 1'b0;
      flg_m = 1 << i;
      settle();
      `CHK(standby_wake, 1'(i < 3))
      check_irq();
      rdc(isv_pkg::OFF_FLAGS, 32'(1 << i));
      line_pin_n[i] <= 1'b1;
      flg_m = 0;
      repeat (16) @(posedge pclk);
      #1;
      check_irq();
    end
    // edge mode, line 4 disabled, flags cleared only by writes of 0 after a read of 1
    accept <= 1'b0;
    apb(1'b1, isv_pkg::OFF_SENSE, 32'h1F);
    apb(1'b1, isv_pkg::OFF_ENABLE, 32'h0F);
    en_m = 15;
    line_pin_n <= 5'h00;
    repeat (2) @(posedge pclk);
    line_pin_n <= 5'h1F;
    flg_m = 31;
    settle();
    check_irq();
    rdc(isv_pkg::OFF_FLAGS, 32'h1F);
    apb(1'b1, isv_pkg::OFF_FLAGS, 32'h10);
    flg_m = 16;
    accept <= 1'b1;
    repeat (40) @(posedge pclk);
    #1;
    check_irq();
    rdc(isv_pkg::OFF_FLAGS, 32'h10);
    apb(1'b1, isv_pkg::OFF_FLAGS, 32'h00);
    flg_m = 0;
    // edge mode: the core's handling alone clears line 4, pin still low
    apb(1'b1, isv_pkg::OFF_ENABLE, 32'h1F);
    en_m = 31;
    line_pin_n <= 5'h0F;
    repeat (20) @(posedge pclk);
    #1;
    check_irq();
    rdc(isv_pkg::OFF_FLAGS, 32'h0);
    rdc(isv_pkg::OFF_HANDLED, 32'h10);
    line_pin_n <= 5'h1F;
    // nmi against a level 1 source, both edge selections
    accept <= 1'b0;
    cnv <= 1'b1;
    apb(1'b1, isv_pkg::OFF_PRIO_2, 32'h02);
    p2_m = 2;
    apb(1'b1, isv_pkg::OFF_SYSCTL, 32'h04);
    nmi_pin <= 1'b1;
    nmi_m = 1;
    settle();
    check_irq();
    rdc(isv_pkg::OFF_STATUS, 32'h7007);
    for (int k = 0; k < 2; k++) begin
      accept <= 1'b1;
      repeat (14) @(posedge pclk);
      accept <= 1'b0;
      nmi_m = 0;
      settle();
      check_irq();
      if (k == 0) apb(1'b1, isv_pkg::OFF_SYSCTL, 32'h00);
      nmi_pin <= ~nmi_pin;
      nmi_m = 1 - k;
      settle();
      check_irq();
    end
    // random sources, enables, pins and priority bits against the model
    apb(1'b1, isv_pkg::OFF_SENSE, 32'h00);
    for (int k = 0; k < 40; k++) begin
      r = xs();
      if (k > 0) begin
        {p1_m, p2_m, en_m} = {24'h0, r[7:0], 24'h0, r[15:8], 27'h0, r[20:16]};
        apb(1'b1, isv_pkg::OFF_PRIO_1, 32'(p1_m));
        apb(1'b1, isv_pkg::OFF_PRIO_2, 32'(p2_m));
        apb(1'b1, isv_pkg::OFF_ENABLE, 32'(en_m));
      end
      r = xs();
      {cha, chb, ovf, wdt, ser, cnv} <= r[20:0];
      line_pin_n <= r[25:21] | r[30:26] | {4'h0, r[31]};
      flg_m |= ~(r[25:21] | r[30:26] | {4'h0, r[31]}) & 31;
      settle();
      check_irq();
    end
    final_report();
  end
endmodule
